/* hw/fvf_pkg.sv */
/*
 Shared constants, types and helpers for the verify / format / deleted-write sequencer.
 Assumes one 100 MHz clock, a synchronous active-low reset and a byte-level drive interface.
*/
// Functional notes
// - Deleted-write writes sectors like normal writes but with the deleted data mark.
// - Verify reads each addressed sector, checks its CRC, passes no data to host.
// - End-of-transfer input never ends a verify command.
// - With enable_count, verify counts sectors down; end at zero; zero start means 256.
// - Without enable_count, final sector above sectors per side fails; else success.
// - With enable_count, count beyond remaining sectors or bad final sector fails.
// - With multi_track, verify continues on side 1 after side 0 runs out.
// - Format waits for index, then writes the track; MFM or FM by density.
// - Format takes sector size, sector total and gap from command bytes.
// - Format fills every data byte with the command fill byte.
// - Host supplies four ID bytes per sector; device writes them into the ID field.
// - Format writes sector total sectors, then runs gap until the next index pulse, then ends.
// - MFM layout: 80 gap, sync, C2 marks, 50 gap, A1 header, 22 gap, A1 data.
// - FM layout: 40 gap, 6 sync, FC, 26 gap, FE header, 11 gap, data mark.
// - Size code maps 00..05 to 128..4096 byte sectors.
// - Control commands move no data and raise no completion here.
// - CRC mismatch sets abnormal end cause, crc fault, ID flag for ID field only, ends command.
// - Write end or host underrun inside a data field pads the rest with zeros.
package fvf_pkg;

	localparam logic [7:0]  FVF_GAP_MFM      = 8'h4e;
	localparam logic [7:0]  FVF_GAP_FM       = 8'hff;
	localparam logic [7:0]  FVF_SYNC_BYTE    = 8'h00;
	localparam logic [7:0]  FVF_PAD_BYTE     = 8'h00;
	localparam logic [7:0]  FVF_IAM_PRE      = 8'hc2;
	localparam logic [7:0]  FVF_MARK_PRE     = 8'ha1;
	localparam logic [7:0]  FVF_INDEX_MARK   = 8'hfc;
	localparam logic [7:0]  FVF_HEADER_MARK  = 8'hfe;
	localparam logic [7:0]  FVF_DATA_MARK    = 8'hfb;
	localparam logic [7:0]  FVF_DELETED_MARK = 8'hf8;
	localparam logic [12:0] FVF_GAP4A_MFM    = 13'h0050;
	localparam logic [12:0] FVF_GAP4A_FM     = 13'h0028;
	localparam logic [12:0] FVF_SYNC_MFM     = 13'h000c;
	localparam logic [12:0] FVF_SYNC_FM      = 13'h0006;
	localparam logic [12:0] FVF_GAP1_MFM     = 13'h0032;
	localparam logic [12:0] FVF_GAP1_FM      = 13'h001a;
	localparam logic [12:0] FVF_GAP2_MFM     = 13'h0016;
	localparam logic [12:0] FVF_GAP2_FM      = 13'h000b;
	localparam logic [12:0] FVF_PRE_LEN      = 13'h0003;
	localparam logic [12:0] FVF_ID_LEN       = 13'h0004;
	localparam logic [12:0] FVF_CRC_LEN      = 13'h0002;
	localparam logic [12:0] FVF_ONE          = 13'h0001;
	localparam logic [12:0] FVF_SECTOR_BASE  = 13'h0080;
	localparam logic [7:0]  FVF_MAX_SIZE     = 8'h05;
	localparam logic [15:0] FVF_CRC_PRESET   = 16'hffff;
	localparam logic [15:0] FVF_CRC_POLY     = 16'h1021;
	localparam logic [1:0]  FVF_END_NORMAL   = 2'h0;
	localparam logic [1:0]  FVF_END_ABNORMAL = 2'h1;
	localparam logic [8:0]  FVF_COUNT_ONE    = 9'h001;
	localparam logic [7:0]  FVF_FIRST_SECTOR = 8'h01;
	localparam logic [7:0]  FVF_SIDE_ONE     = 8'h01;

	typedef enum logic [1:0] {
		FVF_OP_WRITE_DELETED = 2'b00,
		FVF_OP_VERIFY        = 2'b01,
		FVF_OP_FORMAT        = 2'b10,
		FVF_OP_CONTROL       = 2'b11
	} fvf_op_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'h00, S_WAIT_IDX = 5'h01, S_GAP4A = 5'h02, S_SYNC_IAM = 5'h03,
		S_IAM_PRE = 5'h04, S_IAM = 5'h05, S_GAP1 = 5'h06, S_SYNC_ID = 5'h07,
		S_ID_PRE = 5'h08, S_ID_MARK = 5'h09, S_ID_BYTES = 5'h0a, S_ID_CRC = 5'h0b,
		S_GAP2 = 5'h0c, S_SYNC_DATA = 5'h0d, S_DATA_PRE = 5'h0e, S_DATA_MARK = 5'h0f,
		S_DATA = 5'h10, S_DATA_CRC = 5'h11, S_GAP3 = 5'h12, S_GAP4B = 5'h13,
		S_SEARCH = 5'h14, S_RD_ID = 5'h15, S_RD_DAM = 5'h16, S_RD_DATA = 5'h17,
		S_RESULT = 5'h18
	} fvf_state_t;

	typedef struct packed {
		logic [7:0] ring_index;
		logic [7:0] side_sel;
		logic [7:0] slot_id;
		logic [7:0] size_code;
	} fvf_id_t;

	typedef struct packed {
		fvf_op_t    op;
		logic       mfm;
		logic       multi_track;
		logic       enable_count;
		fvf_id_t    id;
		logic [7:0] final_sector_number;
		logic [7:0] gap_length;
		logic [7:0] sector_count;
		logic [7:0] fill_byte;
	} fvf_cmd_t;

	typedef struct packed {
		logic [1:0] end_cause;
		logic       crc_fault_flag;
		logic       id_crc_flag;
		logic       valid;
		fvf_id_t    id;
	} fvf_result_t;

	function automatic logic [12:0] fvf_sector_len(input logic [7:0] size_code);
		logic [7:0] s;
		s = (size_code > FVF_MAX_SIZE) ? FVF_MAX_SIZE : size_code;
		return FVF_SECTOR_BASE << s[2:0];
	endfunction

	function automatic logic [12:0] fvf_pick(input logic mfm, input logic [12:0] mfm_len,
		input logic [12:0] fm_len);
		return mfm ? mfm_len : fm_len;
	endfunction

	function automatic logic fvf_is_write(input fvf_state_t s);
		return (s >= S_GAP4A) && (s <= S_GAP4B);
	endfunction

endpackage

/* hw/fvf_crc16.sv */
/*
 Byte-wide CRC engine for ID and data fields.
 Assumes the caller pulses start on the first address mark byte and feed on every covered byte.
*/
module fvf_crc16
	import fvf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic        feed,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc_q,
	output logic      [15:0] crc_nx
);

	function automatic logic [15:0] crc_byte(input logic [15:0] seed, input logic [7:0] d);
		logic [15:0] c;
		c = seed;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ d[i]) begin
				c = {c[14:0], 1'b0} ^ FVF_CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction

	always_comb begin
		crc_nx = crc_q;
		if (feed) begin
			crc_nx = crc_byte(start ? FVF_CRC_PRESET : crc_q, data);
		end else if (start) begin
			crc_nx = FVF_CRC_PRESET;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			crc_q <= FVF_CRC_PRESET;
		end else begin
			crc_q <= crc_nx;
		end
	end

endmodule

/* hw/fvf_sequencer.sv */
/*
 Execution sequencer for deleted-write, verify and format-track commands.
 Assumes a data separator on the same clock giving byte_tick, a decoded read byte stream
 with mark flags, and a write path that serialises wr_data with wr_mark as missing clock.
*/
module fvf_sequencer
	import fvf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        cmd_start,
	input  wire fvf_cmd_t    cmd,
	input  wire logic [7:0]  sectors_per_side,
	input  wire logic        id_valid,
	input  wire fvf_id_t     id_in,
	output logic             id_ready,
	input  wire logic        host_valid,
	input  wire logic [7:0]  host_data,
	output logic             host_ready,
	input  wire logic        index_pulse_input,
	input  wire logic        end_of_transfer_input,
	input  wire logic        byte_tick,
	input  wire logic        rd_valid,
	input  wire logic [7:0]  rd_byte,
	input  wire logic        rd_mark,
	output logic             wr_gate,
	output logic             wr_strobe,
	output logic [7:0]       wr_data,
	output logic             wr_mark,
	output logic             busy,
	output logic             done,
	output fvf_result_t      result
);

	fvf_state_t  state_reg, state_next;
	logic [12:0] cnt_reg, cnt_next;
	fvf_cmd_t    cmd_reg, cmd_next;
	fvf_id_t     cur_reg, cur_next;
	fvf_id_t     rid_reg, rid_next;
	logic [8:0]  count_reg, count_next;
	logic        pad_reg, pad_next;
	logic        tc_seen_reg, tc_seen_next;
	logic        fin_reg, fin_next;
	logic        fail_reg, fail_next;
	logic        mark_run_reg, mark_run_next;
	logic        idx_s1_reg, idx_s2_reg, idx_s3_reg;
	logic        tc_s1_reg, tc_s2_reg;
	fvf_result_t res_reg, res_next;
	logic        busy_reg, busy_next;
	logic        done_reg, done_next;
	logic        id_ready_reg, id_ready_next;
	logic        host_ready_reg, host_ready_next;
	logic        wr_gate_reg, wr_gate_next;
	logic        wr_strobe_reg, wr_strobe_next;
	logic [7:0]  wr_data_reg, wr_data_next;
	logic        wr_mark_reg, wr_mark_next;

	logic [7:0]  emit;
	logic        emit_mark;
	logic        emit_start;
	logic        emit_feed;
	logic [12:0] len;
	fvf_state_t  follow;
	logic        take;
	logic        crc_start, crc_feed;
	logic [7:0]  crc_data;
	logic [15:0] crc_q, crc_nx;
	logic        idx_edge;
	logic        is_wd, is_verify, is_format;
	logic        last_sec, to_side1, cnt_hit, sec_end, sec_fail, id_match;
	logic [12:0] sec_len;
	logic [7:0]  gap_byte;

	fvf_crc16 u_crc (
		.clock  (clock),
		.rst_n  (rst_n),
		.start  (crc_start),
		.feed   (crc_feed),
		.data   (crc_data),
		.crc_q  (crc_q),
		.crc_nx (crc_nx)
	);

	assign is_wd     = (cmd_reg.op == FVF_OP_WRITE_DELETED);
	assign is_verify = (cmd_reg.op == FVF_OP_VERIFY);
	assign is_format = (cmd_reg.op == FVF_OP_FORMAT);
	assign idx_edge  = idx_s2_reg && !idx_s3_reg;
	assign gap_byte  = cmd_reg.mfm ? FVF_GAP_MFM : FVF_GAP_FM;
	assign sec_len   = fvf_sector_len(cmd_reg.id.size_code);
	assign last_sec  = (cur_reg.slot_id == cmd_reg.final_sector_number);
	assign to_side1  = last_sec && cmd_reg.multi_track && (cur_reg.side_sel != FVF_SIDE_ONE);
	assign cnt_hit   = is_verify && cmd_reg.enable_count && (count_reg == FVF_COUNT_ONE);
	// Running out of track before the count empties means the count was too large
	assign sec_fail  = is_verify && cmd_reg.enable_count && !cnt_hit && last_sec && !to_side1;
	assign sec_end   = cnt_hit || (last_sec && !to_side1) || (is_wd && tc_seen_reg);
	assign id_match  = (rid_reg.slot_id == cur_reg.slot_id)
		&& (rid_reg.side_sel == cur_reg.side_sel)
		&& (rid_reg.ring_index == cur_reg.ring_index);
	assign take      = (state_reg == S_DATA) && is_wd && !pad_reg && !tc_seen_reg && host_valid;

	// Byte emission table for the track writer
	always_comb begin
		emit       = gap_byte;
		emit_mark  = 1'b0;
		emit_start = 1'b0;
		emit_feed  = 1'b0;
		len        = FVF_ONE;
		follow     = state_reg;
		unique case (state_reg)
			S_GAP4A: begin
				len    = fvf_pick(cmd_reg.mfm, FVF_GAP4A_MFM, FVF_GAP4A_FM);
				follow = S_SYNC_IAM;
			end
			S_SYNC_IAM: begin
				emit   = FVF_SYNC_BYTE;
				len    = fvf_pick(cmd_reg.mfm, FVF_SYNC_MFM, FVF_SYNC_FM);
				follow = cmd_reg.mfm ? S_IAM_PRE : S_IAM;
			end
			S_IAM_PRE: begin
				emit      = FVF_IAM_PRE;
				emit_mark = 1'b1;
				len       = FVF_PRE_LEN;
				follow    = S_IAM;
			end
			S_IAM: begin
				emit      = FVF_INDEX_MARK;
				emit_mark = 1'b1;
				follow    = S_GAP1;
			end
			S_GAP1: begin
				len    = fvf_pick(cmd_reg.mfm, FVF_GAP1_MFM, FVF_GAP1_FM);
				follow = S_GAP4B;
			end
			S_SYNC_ID: begin
				emit   = FVF_SYNC_BYTE;
				len    = fvf_pick(cmd_reg.mfm, FVF_SYNC_MFM, FVF_SYNC_FM);
				follow = cmd_reg.mfm ? S_ID_PRE : S_ID_MARK;
			end
			S_ID_PRE: begin
				emit       = FVF_MARK_PRE;
				emit_mark  = 1'b1;
				emit_start = (cnt_reg == '0);
				emit_feed  = 1'b1;
				len        = FVF_PRE_LEN;
				follow     = S_ID_MARK;
			end
			S_ID_MARK: begin
				emit       = FVF_HEADER_MARK;
				emit_mark  = 1'b1;
				emit_start = !cmd_reg.mfm;
				emit_feed  = 1'b1;
				follow     = S_ID_BYTES;
			end
			S_ID_BYTES: begin
				emit      = cur_reg[31 - 8 * cnt_reg[1:0] -: 8];
				emit_feed = 1'b1;
				len       = FVF_ID_LEN;
				follow    = S_ID_CRC;
			end
			S_ID_CRC, S_DATA_CRC: begin
				emit   = cnt_reg[0] ? crc_q[7:0] : crc_q[15:8];
				len    = FVF_CRC_LEN;
				follow = (state_reg == S_ID_CRC) ? S_GAP2 : S_GAP3;
			end
			S_GAP2: begin
				len    = fvf_pick(cmd_reg.mfm, FVF_GAP2_MFM, FVF_GAP2_FM);
				follow = S_SYNC_DATA;
			end
			S_SYNC_DATA: begin
				emit   = FVF_SYNC_BYTE;
				len    = fvf_pick(cmd_reg.mfm, FVF_SYNC_MFM, FVF_SYNC_FM);
				follow = cmd_reg.mfm ? S_DATA_PRE : S_DATA_MARK;
			end
			S_DATA_PRE: begin
				emit       = FVF_MARK_PRE;
				emit_mark  = 1'b1;
				emit_start = (cnt_reg == '0);
				emit_feed  = 1'b1;
				len        = FVF_PRE_LEN;
				follow     = S_DATA_MARK;
			end
			S_DATA_MARK: begin
				emit       = is_wd ? FVF_DELETED_MARK : FVF_DATA_MARK;
				emit_mark  = 1'b1;
				emit_start = !cmd_reg.mfm;
				emit_feed  = 1'b1;
				follow     = S_DATA;
			end
			S_DATA: begin
				emit      = is_format ? cmd_reg.fill_byte : (take ? host_data : FVF_PAD_BYTE);
				emit_feed = 1'b1;
				len       = sec_len;
				follow    = S_DATA_CRC;
			end
			S_GAP3: begin
				len    = (cmd_reg.gap_length == 8'h00) ? FVF_ONE : {5'h00, cmd_reg.gap_length};
				follow = is_wd ? (fin_reg ? S_RESULT : S_SEARCH) : S_GAP4B;
			end
			default: begin
				follow = state_reg;
			end
		endcase
	end

	always_comb begin
		state_next      = state_reg;
		cnt_next        = cnt_reg;
		cmd_next        = cmd_reg;
		cur_next        = cur_reg;
		rid_next        = rid_reg;
		count_next      = count_reg;
		pad_next        = pad_reg;
		tc_seen_next    = tc_seen_reg || (tc_s2_reg && is_wd);
		fin_next        = fin_reg;
		fail_next       = fail_reg;
		mark_run_next   = rd_valid ? rd_mark : mark_run_reg;
		res_next        = res_reg;
		busy_next       = busy_reg;
		done_next       = 1'b0;
		id_ready_next   = 1'b0;
		host_ready_next = 1'b0;
		wr_strobe_next  = 1'b0;
		wr_data_next    = wr_data_reg;
		wr_mark_next    = wr_mark_reg;
		crc_start       = rd_valid && rd_mark && !mark_run_reg;
		crc_feed        = rd_valid && !fvf_is_write(state_reg);
		crc_data        = rd_byte;
		unique case (state_reg)
			S_IDLE: begin
				if (cmd_start && (cmd.op != FVF_OP_CONTROL)) begin
					cmd_next     = cmd;
					cur_next     = cmd.id;
					count_next   = {cmd.sector_count == 8'h00, cmd.sector_count};
					pad_next     = 1'b0;
					tc_seen_next = 1'b0;
					fin_next     = 1'b0;
					fail_next    = 1'b0;
					cnt_next     = '0;
					res_next     = '0;
					busy_next    = 1'b1;
					unique case (cmd.op)
						FVF_OP_VERIFY: begin
							// Final sector past side end can never be reached
							if (cmd.final_sector_number > sectors_per_side) begin
								fail_next  = 1'b1;
								state_next = S_RESULT;
							end else begin
								state_next = S_SEARCH;
							end
						end
						FVF_OP_FORMAT: state_next = S_WAIT_IDX;
						default: state_next = S_SEARCH;
					endcase
				end
			end
			S_WAIT_IDX: begin
				if (idx_edge) begin
					state_next = S_GAP4A;
					cnt_next   = '0;
				end
			end
			S_SEARCH: begin
				if (rd_valid && rd_mark && (rd_byte == FVF_HEADER_MARK)) begin
					state_next = S_RD_ID;
					cnt_next   = '0;
				end
			end
			S_RD_ID: begin
				if (rd_valid) begin
					cnt_next = cnt_reg + FVF_ONE;
					if (cnt_reg < FVF_ID_LEN) begin
						rid_next = {rid_reg[23:0], rd_byte};
					end
					if (cnt_reg == FVF_ID_LEN + FVF_ONE) begin
						cnt_next = '0;
						if (crc_nx != 16'h0000) begin
							res_next.crc_fault_flag = 1'b1;
							res_next.id_crc_flag    = 1'b1;
							fail_next               = 1'b1;
							state_next              = S_RESULT;
						end else if (id_match) begin
							state_next = is_wd ? S_GAP2 : S_RD_DAM;
						end else begin
							state_next = S_SEARCH;
						end
					end
				end
			end
			S_RD_DAM: begin
				if (rd_valid && rd_mark
					&& ((rd_byte == FVF_DATA_MARK) || (rd_byte == FVF_DELETED_MARK))) begin
					state_next = S_RD_DATA;
					cnt_next   = '0;
				end
			end
			S_RD_DATA: begin
				// Bytes are only checked, never handed to the host
				if (rd_valid) begin
					cnt_next = cnt_reg + FVF_ONE;
					if (cnt_reg == sec_len + FVF_ONE) begin
						cnt_next = '0;
						if (crc_nx != 16'h0000) begin
							res_next.crc_fault_flag = 1'b1;
							fail_next               = 1'b1;
							state_next              = S_RESULT;
						end else begin
							count_next = cmd_reg.enable_count ? count_reg - FVF_COUNT_ONE : count_reg;
							cur_next.slot_id  = to_side1 ? FVF_FIRST_SECTOR : cur_reg.slot_id + 8'h01;
							cur_next.side_sel = to_side1 ? FVF_SIDE_ONE : cur_reg.side_sel;
							fail_next  = sec_fail;
							state_next = sec_end ? S_RESULT : S_SEARCH;
						end
					end
				end
			end
			S_RESULT: begin
				res_next.end_cause = fail_reg ? FVF_END_ABNORMAL : FVF_END_NORMAL;
				res_next.valid     = !fail_reg;
				res_next.id        = cur_reg;
				busy_next          = 1'b0;
				done_next          = 1'b1;
				state_next         = S_IDLE;
			end
			default: begin
				if (byte_tick) begin
					wr_strobe_next = 1'b1;
					wr_data_next   = emit;
					wr_mark_next   = emit_mark;
					crc_start      = emit_start;
					crc_feed       = emit_feed;
					crc_data       = emit;
					cnt_next       = cnt_reg + FVF_ONE;
					host_ready_next = take;
					if ((state_reg == S_DATA) && is_wd && !take) begin
						pad_next = 1'b1;
					end
					if (state_reg == S_GAP4B) begin
						cnt_next = '0;
						// Gap keeps running while the host is late or the track is full
						if (id_valid && (count_reg != '0)) begin
							cur_next      = id_in;
							id_ready_next = 1'b1;
							count_next    = count_reg - FVF_COUNT_ONE;
							state_next    = S_SYNC_ID;
							// First sync byte goes out now, so the gap keeps its exact length
							wr_data_next  = FVF_SYNC_BYTE;
							cnt_next      = FVF_ONE;
						end
					end else if (cnt_reg == len - FVF_ONE) begin
						cnt_next   = '0;
						state_next = follow;
						if ((state_reg == S_DATA_CRC) && is_wd) begin
							fin_next          = sec_end;
							cur_next.slot_id  = to_side1 ? FVF_FIRST_SECTOR : cur_reg.slot_id + 8'h01;
							cur_next.side_sel = to_side1 ? FVF_SIDE_ONE : cur_reg.side_sel;
						end
						if (state_reg == S_GAP3) begin
							pad_next = 1'b0;
						end
					end
				end
				if (is_format && idx_edge) begin
					state_next     = S_RESULT;
					wr_strobe_next = 1'b0;
				end
			end
		endcase
		wr_gate_next = fvf_is_write(state_next);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg      <= S_IDLE;
			cnt_reg        <= '0;
			cmd_reg        <= '0;
			cur_reg        <= '0;
			rid_reg        <= '0;
			count_reg      <= '0;
			pad_reg        <= 1'b0;
			tc_seen_reg    <= 1'b0;
			fin_reg        <= 1'b0;
			fail_reg       <= 1'b0;
			mark_run_reg   <= 1'b0;
			idx_s1_reg     <= 1'b0;
			idx_s2_reg     <= 1'b0;
			idx_s3_reg     <= 1'b0;
			tc_s1_reg      <= 1'b0;
			tc_s2_reg      <= 1'b0;
			res_reg        <= '0;
			busy_reg       <= 1'b0;
			done_reg       <= 1'b0;
			id_ready_reg   <= 1'b0;
			host_ready_reg <= 1'b0;
			wr_gate_reg    <= 1'b0;
			wr_strobe_reg  <= 1'b0;
			wr_data_reg    <= 8'h00;
			wr_mark_reg    <= 1'b0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			cmd_reg        <= cmd_next;
			cur_reg        <= cur_next;
			rid_reg        <= rid_next;
			count_reg      <= count_next;
			pad_reg        <= pad_next;
			tc_seen_reg    <= tc_seen_next;
			fin_reg        <= fin_next;
			fail_reg       <= fail_next;
			mark_run_reg   <= mark_run_next;
			idx_s1_reg     <= index_pulse_input;
			idx_s2_reg     <= idx_s1_reg;
			idx_s3_reg     <= idx_s2_reg;
			tc_s1_reg      <= end_of_transfer_input;
			tc_s2_reg      <= tc_s1_reg;
			res_reg        <= res_next;
			busy_reg       <= busy_next;
			done_reg       <= done_next;
			id_ready_reg   <= id_ready_next;
			host_ready_reg <= host_ready_next;
			wr_gate_reg    <= wr_gate_next;
			wr_strobe_reg  <= wr_strobe_next;
			wr_data_reg    <= wr_data_next;
			wr_mark_reg    <= wr_mark_next;
		end
	end

	assign id_ready   = id_ready_reg;
	assign host_ready = host_ready_reg;
	assign wr_gate    = wr_gate_reg;
	assign wr_strobe  = wr_strobe_reg;
	assign wr_data    = wr_data_reg;
	assign wr_mark    = wr_mark_reg;
	assign busy       = busy_reg;
	assign done       = done_reg;
	assign result     = res_reg;

endmodule

/* tb/fvf_sequencer_asserts.sv */
/*
 Port checker for fvf_sequencer.
 Assumes the bind below reaches every sequencer instance.
*/
module fvf_chk
	import fvf_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        cmd_start,
	input wire fvf_cmd_t    cmd,
	input wire logic [7:0]  sectors_per_side,
	input wire logic        id_valid,
	input wire logic        id_ready,
	input wire logic        host_ready,
	input wire logic        byte_tick,
	input wire logic        wr_gate,
	input wire logic        wr_strobe,
	input wire logic [7:0]  wr_data,
	input wire logic        wr_mark,
	input wire logic        busy,
	input wire logic        done,
	input wire fvf_result_t result
);
	fvf_op_t op_reg;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clock) begin
		if (!rst_n)
			op_reg <= FVF_OP_CONTROL;
		else if (cmd_start && !busy)
			op_reg <= cmd.op;
	end
	busy_on_accept_a: assert property (cmd_start && !busy && cmd.op != FVF_OP_CONTROL |=> busy)
		else $error("busy missing after accept");
	done_ends_busy_a: assert property (done |-> !busy && $past(busy))
		else $error("done without busy end");
	control_ignored_a: assert property (cmd_start && !busy && cmd.op == FVF_OP_CONTROL
		|=> !busy ##1 !done)
		else $error("control op started");
	verify_reject_a: assert property (cmd_start && !busy && cmd.op == FVF_OP_VERIFY
		&& cmd.final_sector_number > sectors_per_side
		|=> busy ##1 (done && !result.valid && result.end_cause == FVF_END_ABNORMAL))
		else $error("verify bound not refused");
	verify_quiet_a: assert property (busy && op_reg == FVF_OP_VERIFY |-> !wr_gate && !host_ready)
		else $error("verify moved data");
	strobe_tick_a: assert property (wr_strobe |-> $past(byte_tick))
		else $error("strobe without tick");
	mark_set_a: assert property (wr_strobe && wr_mark |-> wr_data inside
		{8'hc2, 8'ha1, 8'hfc, 8'hfe, 8'hfb, 8'hf8})
		else $error("bad mark byte");
	format_mark_a: assert property (wr_strobe && wr_mark && op_reg == FVF_OP_FORMAT
		|-> wr_data != FVF_DELETED_MARK)
		else $error("format wrote deleted mark");
	crc_cause_a: assert property (done && result.crc_fault_flag
		|-> result.end_cause == FVF_END_ABNORMAL)
		else $error("crc fault not abnormal");
	id_take_a: assert property (id_ready |-> $past(id_valid) && $past(byte_tick) && busy)
		else $error("id taken without offer");
endmodule
bind fvf_sequencer fvf_chk u_fvf_chk(.clock, .rst_n, .cmd_start, .cmd, .sectors_per_side,
	.id_valid, .id_ready, .host_ready, .byte_tick, .wr_gate, .wr_strobe, .wr_data, .wr_mark,
	.busy, .done, .result);

/* tb/fvf_drive_model.sv */
/*
 Drive model: write byte ticks, index pulses and a read byte stream.
 Assumes the bench calls its tasks just after a rising clock edge.
*/
module fvf_drive_model
	import fvf_pkg::*;
(
	input  wire logic clock,
	output logic      byte_tick,
	output logic      index_pulse_input,
	output logic      rd_valid,
	output logic [7:0] rd_byte,
	output logic      rd_mark
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{byte_tick, index_pulse_input, rd_valid, rd_mark} = 4'h0;
		rd_byte = 8'h00;
		forever begin
			repeat (3) @(posedge clock);
			#1 byte_tick = 1'b1;
			@(posedge clock);
			#1 byte_tick = 1'b0;
		end
	end
	task automatic index();
		@(posedge clock);
		#1 index_pulse_input = 1'b1;
		repeat (3) @(posedge clock);
		#1 index_pulse_input = 1'b0;
	endtask
	// Idle read bus shows the inverse, never a stale copy
	task automatic send(input logic [7:0] b, input logic m);
		@(posedge clock);
		#1 {rd_valid, rd_byte, rd_mark} = {1'b1, b, m};
		@(posedge clock);
		#1 {rd_valid, rd_byte, rd_mark} = {1'b0, ~b, 1'b0};
	endtask
endmodule

/* tb/testbench.sv */
/*
 Self-checking bench for fvf_sequencer: verify refusals, CRC fault, FM and MFM tracks.
 Assumes the drive model and checker are compiled before it.
*/
module testbench
	import fvf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, cmd_start, id_valid, id_ready, host_ready, index_pulse_input;
	logic        end_of_transfer_input, byte_tick, rd_valid, rd_mark, wr_gate, wr_strobe;
	logic        wr_mark, busy, done;
	logic [7:0]  sectors_per_side, rd_byte, wr_data;
	fvf_cmd_t    cmd;
	fvf_id_t     id_in;
	fvf_result_t result;
	logic [9:0]  exp_q[$];
	logic [4:0]  res_q[$];
	logic [9:0]  e_w;
	int          num_errors = 0;
	int          tests_run = 0;
	fvf_sequencer u_fvf_sequencer(.clock, .rst_n, .cmd_start, .cmd, .sectors_per_side, .id_valid,
		.id_in, .id_ready, .host_valid(1'b0), .host_data(8'h00), .host_ready, .index_pulse_input,
		.end_of_transfer_input, .byte_tick, .rd_valid, .rd_byte, .rd_mark, .wr_gate, .wr_strobe,
		.wr_data, .wr_mark, .busy, .done, .result);
	fvf_drive_model u_fvf_drive_model(.clock, .byte_tick, .index_pulse_input, .rd_valid,
		.rd_byte, .rd_mark);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic run(input int n, input logic [7:0] b, input logic m, input logic s = 1'b0);
		repeat (n) exp_q.push_back({s, m, b});
	endtask
	task automatic issue(input fvf_cmd_t c);
		@(posedge clock);
		#1 cmd = c;
		cmd_start = 1'b1;
		@(posedge clock);
		#1 cmd_start = 1'b0;
	endtask
	task automatic wait_for(input bit q_only);
		int i;
		for (i = 0; i < 20000; i++) begin
			if (q_only ? exp_q.size() == 0 : done === 1'b1)
				break;
			@(posedge clock) #1;
		end
		if (i == 20000)
			check(9'h0, 9'h1);
	endtask
	// CRC bytes are skipped: gap and field content carry the layout
	task automatic track(input fvf_cmd_t c);
		logic [7:0] g;
		int s, p;
		g = c.mfm ? 8'h4e : 8'hff;
		s = c.mfm ? 12 : 6;
		p = c.mfm ? 3 : 0;
		if (c.op == FVF_OP_FORMAT) begin
			run(c.mfm ? 80 : 40, g, 1'b0);
			run(s, 8'h00, 1'b0);
			run(p, 8'hc2, 1'b1);
			run(1, 8'hfc, 1'b1);
			run(c.mfm ? 50 : 26, g, 1'b0);
			run(s, 8'h00, 1'b0);
			run(p, 8'ha1, 1'b1);
			run(1, 8'hfe, 1'b1);
			for (int j = 3; j >= 0; j--) run(1, id_in[j*8+:8], 1'b0);
			run(2, 8'h00, 1'b0, 1'b1);
		end
		run(c.mfm ? 22 : 11, g, 1'b0);
		run(s, 8'h00, 1'b0);
		run(p, 8'ha1, 1'b1);
		run(1, c.op == FVF_OP_FORMAT ? 8'hfb : 8'hf8, 1'b1);
		run(128 << c.id.size_code, c.fill_byte, 1'b0);
		run(2, 8'h00, 1'b0, 1'b1);
		run(c.gap_length, g, 1'b0);
	endtask
	always @(posedge clock) begin
		if (id_ready === 1'b1)
			id_valid <= 1'b0;
		if (wr_strobe === 1'b1 && exp_q.size() > 0) begin
			e_w = exp_q.pop_front();
			if (!e_w[9])
				check({wr_mark, wr_data}, e_w[8:0]);
		end
		if (done === 1'b1)
			check({4'h0, result.end_cause, result.crc_fault_flag, result.id_crc_flag, result.valid},
				{4'h0, (res_q.size() > 0 ? res_q.pop_front() : 5'h1f)});
	end
	initial begin
		#400us;
		check(9'h0, 9'h1);
		final_report();
	end
	initial begin
		fvf_cmd_t c;
		int k;
		logic [7:0] sps;
		k = $urandom(32'h88e2c941);
		{rst_n, cmd_start, id_valid, end_of_transfer_input} = 4'h0;
		{cmd, id_in, sectors_per_side} = '0;
		repeat (5) @(posedge clock);
		#1 rst_n = 1'b1;
		for (k = 0; k < 4; k++) begin
			sps = 8'($urandom_range(1, 200));
			sectors_per_side = sps;
			c = '0;
			c.op = FVF_OP_VERIFY;
			c.enable_count = k[0];
			c.multi_track = k[1];
			c.final_sector_number = sps + 8'($urandom_range(1, 50));
			c.sector_count = k[0] ? 8'h01 : 8'hff;
			res_q.push_back(5'h08);
			issue(c);
			wait_for(1'b0);
		end
		c.op = FVF_OP_CONTROL;
		issue(c);
		repeat (3) @(posedge clock) #1;
		check({8'h0, busy}, 9'h0);
		c = '0;
		c.op = FVF_OP_VERIFY;
		c.enable_count = 1'b1;
		c.sector_count = 8'h01;
		c.final_sector_number = 8'h01;
		sectors_per_side = 8'h09;
		end_of_transfer_input = 1'b1;
		res_q.push_back(5'h0e);
		issue(c);
		u_fvf_drive_model.send(8'hfe, 1'b1);
		for (k = 0; k < 6; k++) u_fvf_drive_model.send(k == 2 ? 8'h01 : 8'h00, 1'b0);
		wait_for(1'b0);
		end_of_transfer_input = 1'b0;
		c = '0;
		c.op = FVF_OP_WRITE_DELETED;
		c.mfm = 1'b1;
		c.gap_length = 8'h2a;
		track(c);
		res_q.push_back(5'h01);
		issue(c);
		u_fvf_drive_model.send(8'hfe, 1'b1);
		for (k = 0; k < 6; k++)
			u_fvf_drive_model.send(k < 4 ? 8'h00 : (k[0] ? 8'hf2 : 8'he1), 1'b0);
		wait_for(1'b1);
		wait_for(1'b0);
		for (k = 0; k < 2; k++) begin
			c = '0;
			c.op = FVF_OP_FORMAT;
			c.mfm = k[0];
			c.sector_count = 8'h01;
			c.id.size_code = {7'h0, k[0]};
			c.gap_length = 8'($urandom_range(1, 40));
			c.fill_byte = 8'($urandom);
			id_in = fvf_id_t'($urandom);
			track(c);
			id_valid = 1'b1;
			res_q.push_back(5'h01);
			issue(c);
			u_fvf_drive_model.index();
			wait_for(1'b1);
			repeat (20) @(posedge clock);
			u_fvf_drive_model.index();
			wait_for(1'b0);
		end
		repeat (4) @(posedge clock);
		final_report();
	end
endmodule
